// >>> hdl/spisbd_core.sv
// Our own choices: the address map and register access over Wishbone.
`timescale 1ns/100ps
// Summary of operation
// - byte moving to receive register sets rx_full_flag; request if enabled.
// - dma_select 0: rx_full clears on status read seeing it, then data read.
// - dma_select 1: any data register read clears rx_full_flag.
// - reset sets tx_empty, clears other flags, error enable and baud bits.
// - overflow and mode fault interrupt only while error_irq_enable is 1.
// - byte arriving while receive register full sets overflow; new byte lost.
// - overflow clears on status read seeing it, then data read.
// - slave with fault detection: select rising mid-transfer sets mode fault.
// - master with fault detection: select low sets mode fault.
// - mode fault clears on status read seeing it, then control write.
// - tx handoff to shifter sets tx_empty_flag; request if enabled.
// - data register write clears tx_empty_flag, from CPU or DMA.
// - mode fault sets only with enable; clearing enable keeps flag.
// - master without fault enable ignores select and frees the pin.
// - slave always uses select; enable low only suppresses mode fault.
// - master baud select picks divisor 2, 8, 32 or 128; none in slave.
// - serial clock equals base clock over twice the divisor.
// - data writes go to transmit register, reads from receive register.
// - deselected slave floats its output and ignores serial clock edges.
// - dma_select routes rx/tx events to DMA requests instead of CPU.
module spisbd_core (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic dma_rd_i,
    input wire logic dma_wr_i,
    input wire logic [7:0] dma_dat_i,
    output logic dma_rx_req_o,
    output logic dma_tx_req_o,
    output logic rx_irq_o,
    output logic tx_irq_o,
    output logic err_irq_o,
    input wire logic sck_i,
    output logic sck_o,
    output logic sck_oe_o,
    input wire logic mosi_i,
    output logic mosi_o,
    output logic mosi_oe_o,
    input wire logic miso_i,
    output logic miso_o,
    output logic miso_oe_o,
    input wire logic ss_n_i,
    output logic ss_dedicated_o
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SHIFT = 2'b01,
        ST_DONE = 2'b11
    } spisbd_state_e;

    typedef struct packed {
        spisbd_state_e st;
        logic [7:0] ctrl;
        logic [7:0] stat;
        logic [7:0] tx_data;
        logic [7:0] rx_data;
        logic [7:0] shift;
        logic [3:0] bit_cnt;
        logic phase;
        logic sample;
        logic sck;
        logic mosi;
        logic sck_prev;
        logic ss_prev;
        logic [2:0] seen;
        logic ack;
        logic [31:0] rdata;
    } spisbd_core_s;
    spisbd_core_s state_reg;
    spisbd_core_s state_next;

    logic [2:0] pin_sync;
    logic sck_s;
    logic miso_s;
    logic mosi_s;
    logic ss_n_s;
    logic tick;
    logic master;
    logic enabled;
    logic mf_en;
    logic dma_sel;
    logic req;

    //////////////////////////////////////////////////////////////////////
    // pins pass two flops; select level passes its own two-flop synchroniser
    spisbd_sync #(
        .WIDTH(3)
    ) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i({sck_i, mosi_i, miso_i}),
        .sync_o(pin_sync)
    );
    spisbd_sync #(
        .WIDTH(1)
    ) u_sync_ss (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(ss_n_i),
        .sync_o(ss_n_s)
    );
    assign sck_s = pin_sync[2];
    assign mosi_s = pin_sync[1];
    assign miso_s = pin_sync[0];

    assign master = state_reg.ctrl[spisbd_pkg::CTRL_MASTER];
    assign enabled = state_reg.ctrl[spisbd_pkg::CTRL_ENABLE];
    assign dma_sel = state_reg.ctrl[spisbd_pkg::CTRL_DMA_SEL];
    assign mf_en = state_reg.stat[spisbd_pkg::STAT_MF_EN];

    spisbd_baud u_baud (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(enabled && master && state_reg.st == ST_SHIFT),
        .baud_select_i(state_reg.stat[1:0]),
        .tick_o(tick)
    );

    assign req = cyc_i && stb_i && !state_reg.ack;

    function automatic logic [7:0] lane_merge(input logic [7:0] old,
        input logic [3:0] sel, input logic [31:0] dat);
        lane_merge = sel[0] ? dat[7:0] : old;
    endfunction : lane_merge

    //////////////////////////////////////////////////////////////////////
    always_comb begin
        logic cpu_rd_data;
        logic cpu_wr_data;
        logic rd_data;
        logic wr_data;
        logic rx_done;
        logic tx_load;
        logic mf_set;
        logic sck_edge;
        logic active;
        logic [7:0] in_byte;
        logic in_bit;
        state_next = state_reg;
        cpu_rd_data = 1'b0;
        cpu_wr_data = 1'b0;
        rx_done = 1'b0;
        tx_load = 1'b0;
        mf_set = 1'b0;
        in_byte = 8'h00;
        in_bit = master ? miso_s : mosi_s;
        rd_data = 1'b0;
        wr_data = 1'b0;
        active = enabled && (master || !ss_n_s);
        sck_edge = master ? tick : (sck_s != state_reg.sck_prev);
        state_next.ack = req;
        state_next.sck_prev = sck_s;
        state_next.ss_prev = ss_n_s;

        // bus slave: one wait state, ack in the cycle after the strobe
        if (req) begin
            state_next.rdata = 32'h0000_0000;
            if (adr_i == spisbd_pkg::CTRL_OFFSET) begin
                state_next.rdata[7:0] = state_reg.ctrl;
                if (we_i && sel_i[0]) begin
                    state_next.ctrl = dat_i[7:0] & spisbd_pkg::CTRL_MASK;
                    if (state_reg.seen[1]) begin
                        state_next.stat[spisbd_pkg::STAT_MODE_FAULT] = 1'b0;
                    end
                    state_next.seen[1] = 1'b0;
                end
            end else if (adr_i == spisbd_pkg::STAT_OFFSET) begin
                state_next.rdata[7:0] = state_reg.stat;
                if (we_i) begin
                    state_next.stat = (state_reg.stat & ~spisbd_pkg::STAT_WMASK)
                        | (lane_merge(state_reg.stat, sel_i, dat_i)
                        & spisbd_pkg::STAT_WMASK);
                end else begin
                    // remember which flags this read saw set
                    state_next.seen = {state_reg.stat[spisbd_pkg::STAT_RX_FULL],
                        state_reg.stat[spisbd_pkg::STAT_MODE_FAULT],
                        state_reg.stat[spisbd_pkg::STAT_OVERFLOW]};
                end
            end else if (adr_i == spisbd_pkg::DATA_OFFSET) begin
                state_next.rdata[7:0] = state_reg.rx_data;
                cpu_rd_data = !we_i;
                cpu_wr_data = we_i && sel_i[0];
            end
        end
        rd_data = cpu_rd_data || dma_rd_i;
        wr_data = cpu_wr_data || dma_wr_i;

        if (rd_data) begin
            if (dma_sel || state_reg.seen[2]) begin
                state_next.stat[spisbd_pkg::STAT_RX_FULL] = 1'b0;
            end
            if (state_reg.seen[0]) begin
                state_next.stat[spisbd_pkg::STAT_OVERFLOW] = 1'b0;
            end
            state_next.seen[2] = 1'b0;
            state_next.seen[0] = 1'b0;
        end
        if (wr_data) begin
            state_next.tx_data = cpu_wr_data ? dat_i[7:0] : dma_dat_i;
            state_next.stat[spisbd_pkg::STAT_TX_EMPTY] = 1'b0;
        end

        //////////////////////////////////////////////////////////////////
        // shift engine; slave edges count only while selected
        case (state_reg.st)
            ST_IDLE: begin
                state_next.bit_cnt = 4'h0;
                state_next.phase = 1'b0;
                state_next.sck = state_reg.ctrl[spisbd_pkg::CTRL_CPOL];
                if (active && !state_reg.stat[spisbd_pkg::STAT_TX_EMPTY]) begin
                    state_next.shift = state_reg.tx_data;
                    state_next.mosi = state_reg.tx_data[7];
                    tx_load = 1'b1;
                    state_next.st = ST_SHIFT;
                end else if (active && !master && sck_edge) begin
                    state_next.shift = 8'h00;
                    state_next.phase = 1'b1; // that edge was the leading one
                    state_next.st = ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                state_next.sample = 1'b0;
                if (state_reg.sample) begin
                    // synchronised data lags the pin, so take it a cycle late
                    state_next.shift = {state_reg.shift[6:0], in_bit};
                    if (state_reg.bit_cnt == 4'(spisbd_pkg::BYTE_BITS)) begin
                        state_next.st = ST_DONE;
                    end
                end
                if (!active) begin
                    state_next.st = ST_IDLE;
                end else if (sck_edge) begin
                    state_next.phase = !state_reg.phase;
                    if (master) begin
                        state_next.sck = !state_reg.sck;
                    end
                    if (state_reg.phase) begin
                        state_next.bit_cnt = state_reg.bit_cnt + 4'h1;
                        state_next.sample = 1'b1;
                    end else begin
                        state_next.mosi = state_reg.shift[7];
                    end
                end
            end
            default: begin
                in_byte = state_reg.shift;
                rx_done = 1'b1;
                state_next.st = ST_IDLE;
            end
        endcase

        if (tx_load) begin
            state_next.stat[spisbd_pkg::STAT_TX_EMPTY] = 1'b1;
        end
        if (rx_done) begin
            if (state_reg.stat[spisbd_pkg::STAT_RX_FULL]
                && !state_next.stat[spisbd_pkg::STAT_RX_FULL] == 1'b0) begin
                state_next.stat[spisbd_pkg::STAT_OVERFLOW] = 1'b1;
            end else begin
                state_next.rx_data = in_byte;
                state_next.stat[spisbd_pkg::STAT_RX_FULL] = 1'b1;
            end
        end

        // mode fault detection, set wins over the clear above
        if (enabled && master) begin
            mf_set = !ss_n_s;
        end else if (enabled) begin
            mf_set = ss_n_s && !state_reg.ss_prev && state_reg.st != ST_IDLE;
        end
        if (mf_set && mf_en) begin
            state_next.stat[spisbd_pkg::STAT_MODE_FAULT] = 1'b1;
        end

        if (!enabled) begin
            state_next.st = ST_IDLE;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= '0;
            state_reg.ctrl <= spisbd_pkg::CTRL_RESET;
            state_reg.stat <= spisbd_pkg::STAT_RESET;
            state_reg.sck_prev <= 1'b1;
            state_reg.ss_prev <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    //////////////////////////////////////////////////////////////////////
    assign dat_o = state_reg.rdata;
    assign ack_o = state_reg.ack;
    assign rx_irq_o = state_reg.stat[spisbd_pkg::STAT_RX_FULL]
        && state_reg.ctrl[spisbd_pkg::CTRL_RX_IE] && !dma_sel;
    assign tx_irq_o = state_reg.stat[spisbd_pkg::STAT_TX_EMPTY]
        && state_reg.ctrl[spisbd_pkg::CTRL_TX_IE] && !dma_sel;
    assign dma_rx_req_o = state_reg.stat[spisbd_pkg::STAT_RX_FULL]
        && state_reg.ctrl[spisbd_pkg::CTRL_RX_IE] && dma_sel;
    assign dma_tx_req_o = state_reg.stat[spisbd_pkg::STAT_TX_EMPTY]
        && state_reg.ctrl[spisbd_pkg::CTRL_TX_IE] && dma_sel;
    assign err_irq_o = state_reg.stat[spisbd_pkg::STAT_ERR_IE]
        && (state_reg.stat[spisbd_pkg::STAT_OVERFLOW]
        || state_reg.stat[spisbd_pkg::STAT_MODE_FAULT]);
    assign sck_o = state_reg.sck;
    assign sck_oe_o = enabled && master;
    assign mosi_o = state_reg.mosi;
    assign mosi_oe_o = enabled && master;
    assign miso_o = state_reg.mosi;
    assign miso_oe_o = enabled && !master && !ss_n_s;
    // a master without fault detection hands the select pin back
    assign ss_dedicated_o = enabled && (!master || mf_en);

    //////////////////////////////////////////////////////////////////////
    logic rd_evt;
    assign rd_evt = dma_rd_i || (req && !we_i
        && adr_i == spisbd_pkg::DATA_OFFSET);
    sequence stat_read_rxf_s;
        req && !we_i && adr_i == spisbd_pkg::STAT_OFFSET
            && state_reg.stat[spisbd_pkg::STAT_RX_FULL];
    endsequence
    err_irq_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
        err_irq_o |-> state_reg.stat[spisbd_pkg::STAT_ERR_IE])
        else $error("error interrupt without enable");
    dma_route_a: assert property (@(posedge clk_i) disable iff (rst_i)
        dma_sel |-> !rx_irq_o && !tx_irq_o)
        else $error("cpu request raised while dma selected");
    tx_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
        dma_wr_i && state_reg.stat[spisbd_pkg::STAT_TX_EMPTY]
        |=> !state_reg.stat[spisbd_pkg::STAT_TX_EMPTY])
        else $error("tx empty not cleared by write");
    mf_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        state_reg.stat[spisbd_pkg::STAT_MODE_FAULT] && !req
        |=> state_reg.stat[spisbd_pkg::STAT_MODE_FAULT])
        else $error("mode fault lost without control write");
    mf_master_a: assert property (@(posedge clk_i) disable iff (rst_i)
        enabled && master && mf_en && !ss_n_s
        |=> state_reg.stat[spisbd_pkg::STAT_MODE_FAULT])
        else $error("master select low did not set mode fault");
    rx_seq_a: assert property (@(posedge clk_i) disable iff (rst_i)
        stat_read_rxf_s ##1 !dma_sel && !rd_evt ##0 1'b1
        |=> state_reg.stat[spisbd_pkg::STAT_RX_FULL])
        else $error("rx full cleared without data read");
    miso_float_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ss_n_s |-> !miso_oe_o)
        else $error("deselected slave drives its output");
    rx_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
        state_reg.st == ST_DONE && state_reg.stat[spisbd_pkg::STAT_RX_FULL]
        && !dma_rd_i && !req
        |=> $stable(state_reg.rx_data)
        && state_reg.stat[spisbd_pkg::STAT_OVERFLOW])
        else $error("overflow lost or held byte overwritten");
endmodule : spisbd_core

// >>> hdl/spisbd_pkg.sv
package spisbd_pkg;
    // register word offsets (byte addresses on a 32-bit bus)
    localparam logic [3:0] CTRL_OFFSET = 4'h0;
    localparam logic [3:0] STAT_OFFSET = 4'h4;
    localparam logic [3:0] DATA_OFFSET = 4'h8;
    // control register field positions
    localparam int CTRL_RX_IE = 7;
    localparam int CTRL_DMA_SEL = 5;
    localparam int CTRL_MASTER = 4;
    localparam int CTRL_CPOL = 3;
    localparam int CTRL_CPHA = 2;
    localparam int CTRL_ENABLE = 1;
    localparam int CTRL_TX_IE = 0;
    localparam logic [7:0] CTRL_RESET = 8'h14;
    localparam logic [7:0] CTRL_MASK = 8'hbf;
    // status/control register field positions
    localparam int STAT_RX_FULL = 7;
    localparam int STAT_ERR_IE = 6;
    localparam int STAT_OVERFLOW = 5;
    localparam int STAT_MODE_FAULT = 4;
    localparam int STAT_TX_EMPTY = 3;
    localparam int STAT_MF_EN = 2;
    localparam int STAT_BAUD_HI = 1;
    localparam int STAT_BAUD_LO = 0;
    localparam logic [7:0] STAT_WMASK = 8'h47;
    localparam logic [7:0] STAT_RESET = 8'h08;
    // half-period of the serial clock is the baud divisor in clk cycles
    localparam logic [7:0] BAUD_DIV_00 = 8'h02;
    localparam logic [7:0] BAUD_DIV_01 = 8'h08;
    localparam logic [7:0] BAUD_DIV_10 = 8'h20;
    localparam logic [7:0] BAUD_DIV_11 = 8'h80;
    localparam int BYTE_BITS = 8;
endpackage : spisbd_pkg

// >>> hdl/spisbd_baud.sv
`timescale 1ns/100ps
module spisbd_baud (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic run_i,
    input wire logic [1:0] baud_select_i,
    output logic tick_o
);
    typedef struct packed {
        logic [7:0] cnt;
        logic tick;
    } spisbd_baud_s;
    spisbd_baud_s state_reg;
    spisbd_baud_s state_next;

    function automatic logic [7:0] baud_divisor(input logic [1:0] sel);
        case (sel)
            2'h0: baud_divisor = spisbd_pkg::BAUD_DIV_00;
            2'h1: baud_divisor = spisbd_pkg::BAUD_DIV_01;
            2'h2: baud_divisor = spisbd_pkg::BAUD_DIV_10;
            default: baud_divisor = spisbd_pkg::BAUD_DIV_11;
        endcase
    endfunction : baud_divisor

    // one tick per half serial-clock period: rate = clk / (2 * divisor)
    always_comb begin
        state_next = state_reg;
        state_next.tick = 1'b0;
        if (!run_i) begin
            state_next.cnt = 8'h00;
        end else if (state_reg.cnt >= baud_divisor(baud_select_i) - 8'h01) begin
            state_next.cnt = 8'h00;
            state_next.tick = 1'b1;
        end else begin
            state_next.cnt = state_reg.cnt + 8'h01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign tick_o = state_reg.tick;

    tick_spacing_a: assert property (@(posedge clk_i) disable iff (rst_i)
        tick_o && run_i && baud_select_i == 2'h1 && $stable(baud_select_i)
        |=> !tick_o [*7])
        else $error("baud tick came early for divisor 8");
endmodule : spisbd_baud

// >>> hdl/spisbd_sync.sv
`timescale 1ns/100ps
module spisbd_sync #(
    parameter int WIDTH = 3
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    typedef struct packed {
        logic [WIDTH-1:0] first;
        logic [WIDTH-1:0] second;
    } spisbd_sync_s;
    spisbd_sync_s state_reg;
    spisbd_sync_s state_next;

    if (WIDTH < 1) begin : g_width_check
        $error("spisbd_sync width must be positive");
    end

    always_comb begin
        state_next.first = async_i;
        state_next.second = state_reg.first;
    end

    // pins idle high so the synchroniser resets to ones
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= '1;
        end else begin
            state_reg <= state_next;
        end
    end

    assign sync_o = state_reg.second;
endmodule : spisbd_sync

// >>> tb/spisbd_peer.sv
`timescale 1ns/100ps
module spisbd_peer (
    input wire logic sck_i,
    input wire logic mosi_i,
    input wire logic [7:0] tx_byte_i,
    output logic miso_o,
    output logic [7:0] rx_byte_o,
    output int frames_o
);
    logic [7:0] sh = 8'h00;
    logic [7:0] rx = 8'h00;
    logic live = 1'b0;
    int n = 0;
    initial begin
        miso_o = 1'b0;
        rx_byte_o = 8'h00;
        frames_o = 0;
    end
    // mode 1 slave: drive on the leading edge, sample on the trailing one;
    // live guards against the reset-time x to 0 step counting as an edge
    always @(sck_i) begin
        if (sck_i === 1'b1) begin
            live = 1'b1;
            if (n == 0) sh = tx_byte_i;
            miso_o <= sh[7];
            sh = {sh[6:0], 1'b0};
        end else if (sck_i === 1'b0 && live) begin
            rx = {rx[6:0], mosi_i};
            n = n + 1;
            if (n == 8) begin
                n = 0;
                live = 1'b0;
                rx_byte_o <= rx;
                frames_o <= frames_o + 1;
            end
        end
    end
endmodule : spisbd_peer

// >>> tb/spisbd_core_tb.sv
`timescale 1ns/100ps
module spisbd_core_tb;
    logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
    logic [3:0] adr_i = 4'h0, sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0, dat_o;
    logic dma_rd_i = 0, dma_wr_i = 0, ss_n_i = 1, ack_o;
    logic [7:0] dma_dat_i = 8'h00, pb = 8'h00, tb_b, dexp, prx;
    logic dma_rx_req_o, dma_tx_req_o, rx_irq_o, tx_irq_o, err_irq_o;
    logic sck_o, sck_oe_o, mosi_o, mosi_oe_o, miso_o, miso_oe_o;
    logic ss_dedicated_o, rxf, ovf, pmiso;
    logic [7:0] exq[$];
    int n_errors = 0, cmp_count = 0, cyc_n = 0, frames;
    wire logic s_sck = sck_oe_o ? sck_o : 1'b0;
    wire logic s_mosi = mosi_oe_o ? mosi_o : 1'b0;
    initial forever #10 clk_i = ~clk_i;
    spisbd_core i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
        .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .dma_rd_i(dma_rd_i),
        .dma_wr_i(dma_wr_i), .dma_dat_i(dma_dat_i),
        .dma_rx_req_o(dma_rx_req_o), .dma_tx_req_o(dma_tx_req_o),
        .rx_irq_o(rx_irq_o), .tx_irq_o(tx_irq_o), .err_irq_o(err_irq_o),
        .sck_i(s_sck), .sck_o(sck_o), .sck_oe_o(sck_oe_o), .mosi_i(s_mosi),
        .mosi_o(mosi_o), .mosi_oe_o(mosi_oe_o), .miso_i(pmiso),
        .miso_o(miso_o), .miso_oe_o(miso_oe_o), .ss_n_i(ss_n_i),
        .ss_dedicated_o(ss_dedicated_o));
    spisbd_peer i_peer (.sck_i(s_sck), .mosi_i(s_mosi), .tx_byte_i(pb),
        .miso_o(pmiso), .rx_byte_o(prx), .frames_o(frames));
    ////////////////////////////////////////////////////////////////////////
    task end_sim;
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : end_sim
    task cmp8(input logic [7:0] got, input logic [7:0] exp, input string m);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : cmp8
    task chk1(input logic exp, input int which);
        @(negedge clk_i);
        case (which)
            0: cmp8({7'h0, rx_irq_o}, {7'h0, exp}, "rx irq");
            1: cmp8({7'h0, dma_rx_req_o}, {7'h0, exp}, "dma rx req");
            2: cmp8({7'h0, err_irq_o}, {7'h0, exp}, "err irq");
            4: cmp8({7'h0, tx_irq_o}, {7'h0, exp}, "tx irq");
            5: cmp8({7'h0, dma_tx_req_o}, {7'h0, exp}, "dma tx req");
            6: cmp8({7'h0, miso_oe_o}, {7'h0, exp}, "miso oe");
            default: cmp8({7'h0, ss_dedicated_o}, {7'h0, exp}, "ss pin");
        endcase
    endtask : chk1
    // the read checker pops one note per acknowledged read
    always @(posedge clk_i) begin
        if (ack_o === 1'b1 && we_i === 1'b0 && cyc_i === 1'b1) begin
            if (exq.size() == 0) cmp8(dat_o[7:0], 8'hxx, "unexpected read");
            else cmp8(dat_o[7:0], exq.pop_front(), "read");
        end
    end
    always @(posedge clk_i) begin
        cyc_n++;
        if (cyc_n == 40000) begin
            n_errors++;
            end_sim();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task wb(input logic w, input logic [3:0] a, input logic [7:0] d);
        int i;
        @(posedge clk_i);
        cyc_i <= 1;
        stb_i <= 1;
        we_i <= w;
        adr_i <= a;
        sel_i <= 4'h1;
        dat_i <= {24'h0, d};
        i = 0;
        do begin
            @(posedge clk_i);
            i++;
        end while (ack_o !== 1'b1 && i < 100);
        cyc_i <= 0;
        stb_i <= 0;
        we_i <= 0;
    endtask : wb
    task rd(input logic [3:0] a, input logic [7:0] e);
        exq.push_back(e);
        wb(0, a, 8'h00);
    endtask : rd
    task pulse(input logic wr, input logic [7:0] d);
        @(posedge clk_i);
        if (wr) dma_wr_i <= 1;
        else dma_rd_i <= 1;
        dma_dat_i <= d;
        @(posedge clk_i);
        dma_wr_i <= 0;
        dma_rd_i <= 0;
    endtask : pulse
    // pre loads the transmit byte while disabled so tx_empty can be seen low
    task xfer(input logic [1:0] c, input logic [7:0] ctl, input logic pre,
              input logic dma);
        int f, i, h;
        logic [7:0] bd, pv;
        bd = (c == 0) ? 8'h02 : (c == 1) ? 8'h08 : (c == 2) ? 8'h20 : 8'h80;
        tb_b = 8'($urandom);
        pv = 8'($urandom);
        pb <= pv;
        wb(1, spisbd_pkg::STAT_OFFSET, {6'h0, c});
        if (pre) begin
            wb(1, spisbd_pkg::CTRL_OFFSET, ctl & 8'hfd);
            if (dma) pulse(1, tb_b);
            else wb(1, spisbd_pkg::DATA_OFFSET, tb_b);
            rd(spisbd_pkg::STAT_OFFSET, {rxf, 1'b0, ovf, 3'h0, c});
            wb(1, spisbd_pkg::CTRL_OFFSET, ctl);
        end else wb(1, spisbd_pkg::DATA_OFFSET, tb_b);
        f = frames;
        i = 0;
        while (s_sck !== 1'b1 && i < 5000) begin
            @(negedge clk_i);
            i++;
        end
        h = 0;
        while (s_sck === 1'b1 && h < 500) begin
            @(negedge clk_i);
            h++;
        end
        cmp8(h[7:0], bd, "half period");
        while (frames == f && i < 9000) begin
            @(negedge clk_i);
            i++;
        end
        repeat (16) @(posedge clk_i);
        cmp8(prx, tb_b, "peer rx");
        if (rxf) ovf = 1;
        else dexp = pv;
        rxf = 1;
    endtask : xfer
    ////////////////////////////////////////////////////////////////////////
    initial begin
        tb_b = 8'($urandom(74791));
        rxf = 0;
        ovf = 0;
        repeat (4) @(posedge clk_i);
        rst_i <= 0;
        rd(spisbd_pkg::CTRL_OFFSET, 8'h14);
        rd(spisbd_pkg::STAT_OFFSET, 8'h08);
        rd(4'hc, 8'h00);
        for (int c = 0; c < 4; c++) begin
            xfer(c[1:0], 8'h96, 1, 0);
            chk1(1, 0);
            rd(spisbd_pkg::STAT_OFFSET, 8'h88 | c[7:0]);
            rd(spisbd_pkg::DATA_OFFSET, dexp);
            rxf = 0;
            rd(spisbd_pkg::STAT_OFFSET, 8'h08 | c[7:0]);
        end
        xfer(0, 8'h96, 1, 0);
        xfer(0, 8'h96, 0, 0);
        rd(spisbd_pkg::STAT_OFFSET, 8'ha8);
        rd(spisbd_pkg::DATA_OFFSET, dexp);
        rxf = 0;
        ovf = 0;
        rd(spisbd_pkg::STAT_OFFSET, 8'h08);
        xfer(0, 8'hb6, 1, 1);
        chk1(1, 1);
        chk1(0, 0);
        pulse(0, 8'h00);
        rxf = 0;
        rd(spisbd_pkg::STAT_OFFSET, 8'h08);
        wb(1, spisbd_pkg::CTRL_OFFSET, 8'h96);
        wb(1, spisbd_pkg::STAT_OFFSET, 8'h44);
        chk1(1, 3);
        @(posedge clk_i);
        ss_n_i <= 0;
        repeat (8) @(posedge clk_i);
        chk1(1, 2);
        rd(spisbd_pkg::STAT_OFFSET, 8'h5c);
        wb(1, spisbd_pkg::STAT_OFFSET, 8'h40);
        chk1(0, 3);
        rd(spisbd_pkg::STAT_OFFSET, 8'h58);
        ss_n_i <= 1;
        wb(1, spisbd_pkg::CTRL_OFFSET, 8'h96);
        rd(spisbd_pkg::STAT_OFFSET, 8'h48);
        chk1(0, 2);
        wb(1, spisbd_pkg::CTRL_OFFSET, 8'h97);
        chk1(1, 4);
        chk1(0, 6);
        wb(1, spisbd_pkg::CTRL_OFFSET, 8'hb7);
        chk1(1, 5);
        chk1(0, 4);
        end_sim();
    end
endmodule : spisbd_core_tb
